// ---- rtl/srs_pkg.sv ----
// constants shared by the split/retry slave, the bus master end and the bus interface
// assumes one bus clock and a synchronous active-high reset
`default_nettype none

package srs_pkg;
	// bus geometry
	localparam int DATA_W        = 32;
	localparam int ADDR_W        = 32;
	localparam int MID_W         = 4;
	localparam int MAX_MASTERS   = 16;
	// transfer type codes
	localparam logic [1:0] TR_IDLE   = 2'h0;
	localparam logic [1:0] TR_BUSY   = 2'h1;
	localparam logic [1:0] TR_NONSEQ = 2'h2;
	localparam logic [1:0] TR_SEQ    = 2'h3;
	// response codes
	localparam logic [1:0] RSP_OKAY  = 2'h0;
	localparam logic [1:0] RSP_ERROR = 2'h1;
	localparam logic [1:0] RSP_RETRY = 2'h2;
	localparam logic [1:0] RSP_SPLIT = 2'h3;
	// backing store
	localparam int STORE_DEPTH   = 64;
	localparam int STORE_LATENCY = 4;
	// values after reset
	localparam logic       RST_HREADY = 1'b1;
	localparam logic [7:0] RST_TRIES  = 8'h00;

	// byte lanes touched by a transfer of 2**size bytes at a byte offset
	function automatic logic [127:0] byte_mask(input logic [6:0] offset, input logic [2:0] size);
		logic [7:0]   nbytes;
		logic [6:0]   base;
		logic [127:0] ones;
		nbytes = 8'(8'h01 << size);
		base   = offset & ~7'(nbytes - 8'h01);
		ones   = {128{1'b1}} >> (8'h80 - nbytes);
		return ones << base;
	endfunction
endpackage

`default_nettype wire

// ---- rtl/srs_bus_if.sv ----
// shared system bus between the split-capable slave and the bus master end
// assumes the bench supplies clock and reset; no tri-state wires
`default_nettype none

interface srs_bus_if #(
	parameter int DATA_W = srs_pkg::DATA_W
) (
	input wire logic hclk,
	input wire logic reset
);
	logic                                hsel;
	logic [srs_pkg::ADDR_W-1:0]          haddr;
	logic [1:0]                          htrans;
	logic                                hwrite;
	logic [2:0]                          hsize;
	logic [DATA_W-1:0]                   hwdata;
	logic [srs_pkg::MID_W-1:0]           hmaster;
	logic                                hmastlock;
	logic                                hready;
	logic [1:0]                          hresp;
	logic [DATA_W-1:0]                   hrdata;
	logic [srs_pkg::MAX_MASTERS-1:0]     hsplit;

	modport slave (
		input  hclk, reset, hsel, haddr, htrans, hwrite, hsize, hwdata, hmaster, hmastlock,
		output hready, hresp, hrdata, hsplit
	);
	modport master (
		input  hclk, reset, hready, hresp, hrdata, hsplit,
		output hsel, haddr, htrans, hwrite, hsize, hwdata, hmaster, hmastlock
	);
endinterface

`default_nettype wire

// ---- rtl/srs_store.sv ----
// word store with a fixed access latency, used by the split slave
// assumes start only while busy is low
`default_nettype none

module srs_store #(
	parameter int DATA_W  = srs_pkg::DATA_W,
	parameter int DEPTH   = srs_pkg::STORE_DEPTH,
	parameter int LATENCY = srs_pkg::STORE_LATENCY
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// request
	input  wire logic                     start,
	input  wire logic                     write,
	input  wire logic [$clog2(DEPTH)-1:0] index,
	input  wire logic [DATA_W-1:0]        wdata,
	input  wire logic [DATA_W/8-1:0]      bmask,
	// answer
	output logic                          busy,
	output logic                          done,
	output logic [DATA_W-1:0]             rdata
);
	localparam int CW = $clog2(LATENCY + 1);

	logic [DATA_W-1:0] mem [DEPTH];
	logic [CW-1:0]     count;

	always_ff @(posedge clk) begin
		if (reset) begin
			busy  <= 1'b0;
			done  <= 1'b0;
			count <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy  <= 1'b1;
				count <= CW'(LATENCY - 1);
			end else if (busy) begin
				if (count == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - CW'(1);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (start) begin
			rdata <= mem[index];
			for (int b = 0; b < DATA_W / 8; b++) begin
				if (write && bmask[b]) begin
					mem[index][b*8 +: 8] <= wdata[b*8 +: 8];
				end
			end
		end
	end
endmodule

`default_nettype wire

// ---- rtl/srs_split_slave.sv ----
// split-capable slave end: one address slot, a pending-split vector for all masters
// assumes a single bus clock; the master end obeys idle-after-split and re-issues on release
`default_nettype none

module srs_split_slave #(
	parameter int DATA_W    = srs_pkg::DATA_W,
	parameter int DEPTH     = srs_pkg::STORE_DEPTH,
	parameter int LATENCY   = srs_pkg::STORE_LATENCY,
	parameter bit USE_RETRY = 1'b0,
	parameter bit REPLICATE = 1'b1
) (
	// shared bus
	srs_bus_if.slave                          bus,
	// status to the system
	output logic [srs_pkg::MAX_MASTERS-1:0]   pending,
	output logic                              guard_hit
);
	localparam int         NB       = DATA_W / 8;
	localparam int         LB       = $clog2(NB);
	localparam int         AW       = $clog2(DEPTH);
	localparam logic [2:0] NAT_SIZE = 3'(LB);
	localparam logic [1:0] BUSY_RSP = USE_RETRY ? srs_pkg::RSP_RETRY : srs_pkg::RSP_SPLIT;

	typedef enum logic [2:0] {
		ST_READY = 3'b001,
		ST_RESP1 = 3'b010,
		ST_LOCK  = 3'b100
	} srs_sstate_t;

	srs_sstate_t                     state;
	logic [1:0]                      resp_code;
	logic [srs_pkg::MAX_MASTERS-1:0] pend;
	logic                            slot_valid;
	logic                            slot_done;
	logic                            slot_fresh;
	logic [srs_pkg::MID_W-1:0]       slot_owner;
	logic [srs_pkg::ADDR_W-1:0]      slot_addr;
	logic                            slot_write;
	logic [2:0]                      slot_size;
	logic [DATA_W-1:0]               slot_data;
	logic                            lk_run;
	logic [srs_pkg::ADDR_W-1:0]      lk_addr;
	logic                            lk_write;
	logic [2:0]                      lk_size;

	// expand a byte mask to bit lanes
	function automatic logic [DATA_W-1:0] lane_bits(input logic [NB-1:0] m);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int b = 0; b < NB; b++) begin
			r[b*8 +: 8] = {8{m[b]}};
		end
		return r;
	endfunction

	// read data shaping for the bus
	function automatic logic [DATA_W-1:0] out_data(input logic [DATA_W-1:0] w, input logic [NB-1:0] m);
		return REPLICATE ? w : (w & lane_bits(m));
	endfunction

	// address phase decode
	wire                 take      = (state == ST_READY) && bus.hsel && bus.htrans[1];
	wire                 size_bad  = bus.hsize > NAT_SIZE;
	wire                 is_owner  = slot_valid && (slot_owner == bus.hmaster);
	wire                 dec_err   = take && size_bad;
	wire                 dec_lock  = take && !size_bad && bus.hmastlock;
	wire                 dec_plain = take && !size_bad && !bus.hmastlock;
	wire                 collect   = dec_plain && is_owner && slot_done;
	wire                 again     = dec_plain && is_owner && !slot_done;
	wire                 other     = dec_plain && slot_valid && !is_owner;
	wire                 fresh     = dec_plain && !slot_valid;
	wire [NB-1:0]        slot_mask;
	wire [NB-1:0]        lk_mask;
	wire [127:0]         slot_mask_w;
	wire [127:0]         lk_mask_w;
	wire [srs_pkg::MAX_MASTERS-1:0] req_bit   = srs_pkg::MAX_MASTERS'(1) << bus.hmaster;
	wire [srs_pkg::MAX_MASTERS-1:0] owner_bit = srs_pkg::MAX_MASTERS'(1) << slot_owner;

	assign slot_mask_w = srs_pkg::byte_mask(slot_addr[6:0] & 7'(NB - 1), slot_size);
	assign lk_mask_w   = srs_pkg::byte_mask(lk_addr[6:0] & 7'(NB - 1), lk_size);
	assign slot_mask   = slot_mask_w[NB-1:0];
	assign lk_mask     = lk_mask_w[NB-1:0];

	// store access: slot op starts after its first response cycle, lock op waits for an idle store
	wire                 st_busy;
	wire                 st_done;
	wire [DATA_W-1:0]    st_rdata;
	wire                 in_lock   = state == ST_LOCK;
	wire                 lk_start  = in_lock && !lk_run && !st_busy;
	wire                 sl_start  = (state == ST_RESP1) && slot_fresh;
	wire                 st_start  = lk_start || sl_start;
	wire [srs_pkg::ADDR_W-1:0] st_addr = in_lock ? lk_addr : slot_addr;
	wire                 st_write  = in_lock ? lk_write : slot_write;
	wire [NB-1:0]        st_mask   = in_lock ? lk_mask : slot_mask;
	wire                 lk_end    = in_lock && lk_run && st_done;
	wire                 sl_end    = st_done && !lk_run;

	// split release: owner when its data is ready, all pending masters when the slot frees
	wire [srs_pkg::MAX_MASTERS-1:0] rel_owner = (sl_end && !USE_RETRY) ? owner_bit : '0;
	wire [srs_pkg::MAX_MASTERS-1:0] rel_pend  = collect ? pend : '0;
	wire                            split_any = (other || again || fresh) && !USE_RETRY;
	wire [srs_pkg::MAX_MASTERS-1:0] set_pend  = split_any ? req_bit : '0;
	wire [srs_pkg::MAX_MASTERS-1:0] next_pend = (pend & ~(rel_pend | rel_owner)) | set_pend;
	wire [1:0]           next_other = USE_RETRY ? srs_pkg::RSP_ERROR : srs_pkg::RSP_SPLIT;

	srs_store #(
		.DATA_W  (DATA_W),
		.DEPTH   (DEPTH),
		.LATENCY (LATENCY)
	) u_store (
		.clk   (bus.hclk),
		.reset (bus.reset),
		.start (st_start),
		.write (st_write),
		.index (st_addr[LB +: AW]),
		.wdata (bus.hwdata),
		.bmask (st_mask),
		.busy  (st_busy),
		.done  (st_done),
		.rdata (st_rdata)
	);

	// response and state
	always_ff @(posedge bus.hclk) begin
		if (bus.reset) begin
			state      <= ST_READY;
			resp_code  <= srs_pkg::RSP_OKAY;
			bus.hready <= srs_pkg::RST_HREADY;
			bus.hresp  <= srs_pkg::RSP_OKAY;
			bus.hrdata <= '0;
			guard_hit  <= 1'b0;
			lk_run     <= 1'b0;
		end else begin
			guard_hit <= other && USE_RETRY;
			unique case (state)
				ST_READY: begin
					bus.hready <= 1'b1;
					bus.hresp  <= srs_pkg::RSP_OKAY;
					if (dec_err || again || other || fresh) begin
						bus.hready <= 1'b0;
						state      <= ST_RESP1;
					end
					if (dec_err) begin
						bus.hresp <= srs_pkg::RSP_ERROR;
						resp_code <= srs_pkg::RSP_ERROR;
					end else if (other) begin
						bus.hresp <= next_other;
						resp_code <= next_other;
					end else if (again || fresh) begin
						bus.hresp <= BUSY_RSP;
						resp_code <= BUSY_RSP;
					end else if (dec_lock) begin
						bus.hready <= 1'b0;
						state      <= ST_LOCK;
					end else if (collect) begin
						bus.hrdata <= out_data(slot_data, slot_mask);
					end
				end
				ST_RESP1: begin
					bus.hready <= 1'b1;
					bus.hresp  <= resp_code;
					state      <= ST_READY;
				end
				ST_LOCK: begin
					if (lk_start) begin
						lk_run <= 1'b1;
					end
					if (lk_end) begin
						bus.hready <= 1'b1;
						bus.hrdata <= out_data(st_rdata, lk_mask);
						lk_run     <= 1'b0;
						state      <= ST_READY;
					end
				end
			endcase
		end
	end

	// address slot, lock capture and pending vector
	always_ff @(posedge bus.hclk) begin
		if (bus.reset) begin
			slot_valid   <= 1'b0;
			slot_done    <= 1'b0;
			slot_fresh   <= 1'b0;
			slot_owner   <= '0;
			slot_addr    <= '0;
			slot_write   <= 1'b0;
			slot_size    <= '0;
			slot_data    <= '0;
			lk_addr      <= '0;
			lk_write     <= 1'b0;
			lk_size      <= '0;
			pend         <= '0;
			bus.hsplit   <= '0;
		end else begin
			pend       <= next_pend;
			bus.hsplit <= rel_owner | rel_pend;
			if (fresh) begin
				slot_valid <= 1'b1;
				slot_fresh <= 1'b1;
				slot_owner <= bus.hmaster;
				slot_addr  <= bus.haddr;
				slot_write <= bus.hwrite;
				slot_size  <= bus.hsize;
			end else if (sl_start) begin
				slot_fresh <= 1'b0;
			end
			if (sl_end) begin
				slot_done <= 1'b1;
				slot_data <= st_rdata;
			end
			if (collect) begin
				slot_valid <= 1'b0;
				slot_done  <= 1'b0;
			end
			if (dec_lock) begin
				lk_addr  <= bus.haddr;
				lk_write <= bus.hwrite;
				lk_size  <= bus.hsize;
			end
		end
	end

	assign pending = pend;
endmodule

`default_nettype wire

// ---- rtl/srs_bus_master.sv ----
// bus master end: issues one transfer at a time under a chosen master number
// assumes it is the only master on the bus and also plays decoder and arbiter
`default_nettype none

module srs_bus_master #(
	parameter int DATA_W = srs_pkg::DATA_W
) (
	// shared bus
	srs_bus_if.master                   bus,
	// command
	input  wire logic                   cmd_valid,
	input  wire logic [srs_pkg::MID_W-1:0] cmd_id,
	input  wire logic [srs_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic                   cmd_write,
	input  wire logic [2:0]             cmd_size,
	input  wire logic                   cmd_lock,
	input  wire logic [DATA_W-1:0]      cmd_wdata,
	output logic                        cmd_ready,
	// completion
	output logic                        done,
	output logic                        done_err,
	output logic [DATA_W-1:0]           done_data,
	output logic [7:0]                  done_tries
);
	localparam int         NB       = DATA_W / 8;
	localparam int         LB       = $clog2(NB);
	localparam logic [2:0] NAT_SIZE = 3'(LB);

	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_ADDR = 4'b0010,
		M_DATA = 4'b0100,
		M_PARK = 4'b1000
	} srs_mstate_t;

	srs_mstate_t       state;
	logic              released;
	logic [DATA_W-1:0] wdata;

	wire [6:0]         offset   = bus.haddr[6:0] & 7'(NB - 1);
	wire [9:0]         shift    = {offset, 3'b000};
	wire               my_split = bus.hsplit[bus.hmaster];
	wire               go_again = my_split || released;

	always_ff @(posedge bus.hclk) begin
		if (bus.reset) begin
			state         <= M_IDLE;
			bus.hsel      <= 1'b0;
			bus.haddr     <= '0;
			bus.htrans    <= srs_pkg::TR_IDLE;
			bus.hwrite    <= 1'b0;
			bus.hsize     <= '0;
			bus.hwdata    <= '0;
			bus.hmaster   <= '0;
			bus.hmastlock <= 1'b0;
			cmd_ready     <= 1'b0;
			done          <= 1'b0;
			done_err      <= 1'b0;
			done_data     <= '0;
			done_tries    <= srs_pkg::RST_TRIES;
			released      <= 1'b0;
			wdata         <= '0;
		end else begin
			done <= 1'b0;
			unique case (state)
				M_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						if (cmd_size > NAT_SIZE) begin
							done     <= 1'b1;
							done_err <= 1'b1;
						end else begin
							bus.hsel      <= 1'b1;
							bus.haddr     <= cmd_addr;
							bus.hwrite    <= cmd_write;
							bus.hsize     <= cmd_size;
							bus.hmaster   <= cmd_id;
							bus.hmastlock <= cmd_lock;
							bus.htrans    <= srs_pkg::TR_NONSEQ;
							wdata         <= cmd_wdata;
							done_tries    <= 8'h01;
							state         <= M_ADDR;
						end
					end
				end
				M_ADDR: begin
					released <= 1'b0;
					if (bus.hready) begin
						bus.htrans <= srs_pkg::TR_IDLE;
						bus.hwdata <= DATA_W'(wdata << shift);
						state      <= M_DATA;
					end
				end
				M_DATA: begin
					if (my_split) begin
						released <= 1'b1;
					end
					if (bus.hready) begin
						unique case (bus.hresp)
							srs_pkg::RSP_OKAY, srs_pkg::RSP_ERROR: begin
								done          <= 1'b1;
								done_err      <= bus.hresp == srs_pkg::RSP_ERROR;
								done_data     <= DATA_W'(bus.hrdata >> shift);
								bus.hmastlock <= 1'b0;
								state         <= M_IDLE;
							end
							srs_pkg::RSP_RETRY: begin
								bus.htrans <= srs_pkg::TR_NONSEQ;
								done_tries <= done_tries + 8'h01;
								state      <= M_ADDR;
							end
							srs_pkg::RSP_SPLIT: begin
								state <= M_PARK;
							end
						endcase
					end
				end
				M_PARK: begin
					if (go_again) begin
						bus.htrans <= srs_pkg::TR_NONSEQ;
						done_tries <= done_tries + 8'h01;
						state      <= M_ADDR;
					end
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// ---- verif/srs_bus_assertions.sv ----
// checker for the shared split bus, watching the signals of the bus interface
// assumes one bus clock and a synchronous active-high reset
`default_nettype none

module srs_bus_assertions (
	// clock and reset
	input wire logic                              hclk,
	input wire logic                              reset,
	// master side
	input wire logic                              hsel,
	input wire logic [1:0]                        htrans,
	input wire logic [2:0]                        hsize,
	input wire logic [srs_pkg::MID_W-1:0]         hmaster,
	input wire logic                              hmastlock,
	// slave side
	input wire logic                              hready,
	input wire logic [1:0]                        hresp,
	input wire logic [srs_pkg::MAX_MASTERS-1:0]   hsplit
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MAX_WAIT = 12;
	localparam int MAX_SIZE = 2;
	logic [7:0]  wait_cnt;
	logic [3:0]  data_mid;
	logic [15:0] recorded;
	wire         addr_taken  = hready && hsel && htrans[1];
	wire         split_first = !hready && hresp == srs_pkg::RSP_SPLIT;
	wire [15:0]  split_set   = split_first ? 16'(16'h0001 << data_mid) : 16'h0000;

	// wait counter, master number of the data phase, masters split and not yet released
	always_ff @(posedge hclk) begin
		if (reset) begin
			wait_cnt <= 8'h00;
			data_mid <= 4'h0;
			recorded <= 16'h0000;
		end else begin
			wait_cnt <= hready ? 8'h00 : wait_cnt + 8'h01;
			data_mid <= addr_taken ? hmaster : data_mid;
			recorded <= (recorded & ~hsplit) | split_set;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (reset);

	chk_split_two_cycle: assert property (split_first |=> hready && hresp == srs_pkg::RSP_SPLIT)
		else $error("split response not held for a second cycle");
	chk_split_second_only: assert property (hready && hresp == srs_pkg::RSP_SPLIT |-> $past(split_first))
		else $error("split response without a first low cycle");
	chk_idle_single: assert property (hready && !(hsel && htrans[1]) |=> hready && hresp == srs_pkg::RSP_OKAY)
		else $error("idle transfer not completed in one cycle");
	chk_wait_bounded: assert property (wait_cnt <= MAX_WAIT)
		else $error("ready held low too long");
	chk_oversize_error: assert property (addr_taken && hsize > MAX_SIZE |=>
		!hready && hresp == srs_pkg::RSP_ERROR ##1 hready && hresp == srs_pkg::RSP_ERROR)
		else $error("oversize transfer not answered with error");
	chk_release_recorded: assert property ((hsplit & ~recorded) == 16'h0000)
		else $error("release of a master that was never split");
	chk_split_released: assert property (split_first |-> ##[2:30] hsplit != 16'h0000)
		else $error("split master not released");
	chk_lock_no_split: assert property (addr_taken && hmastlock |=>
		hresp != srs_pkg::RSP_SPLIT && hresp != srs_pkg::RSP_RETRY)
		else $error("locked transfer split or retried");
	chk_reset_quiet: assert property (disable iff (1'b0) reset |=> hready && hresp == srs_pkg::RSP_OKAY
		&& hsplit == 16'h0000 && !hsel && htrans == srs_pkg::TR_IDLE)
		else $error("bus not quiet after reset");

	cov_split: cover property (split_first);
	cov_lock: cover property (addr_taken && hmastlock);
	cov_release: cover property (hsplit != 16'h0000);
endmodule

`default_nettype wire

// ---- verif/split_retry_slave_handling_tb_top.sv ----
// testbench: split slave and master end joined by the bus interface, byte model
// assumes the design defaults (32-bit data, 64-word store, split mode)
`default_nettype none

module split_retry_slave_handling_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DW = srs_pkg::DATA_W;
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	logic          cmd_valid = 1'b0;
	logic [3:0]    cmd_id = 4'h0;
	logic [31:0]   cmd_addr = 32'h0;
	logic          cmd_write = 1'b0;
	logic [2:0]    cmd_size = 3'h0;
	logic          cmd_lock = 1'b0;
	logic [DW-1:0] cmd_wdata = '0;
	logic          cmd_ready, done, done_err, guard_hit;
	logic [DW-1:0] done_data;
	logic [7:0]    done_tries;
	logic [15:0]   pending;
	logic [7:0]    mem [256];
	int            failures = 0;
	int            check_count = 0;
	int            split_cnt = 0;
	int            rel_cnt = 0;
	int            exp_splits = 0;
	int            k;

	always #25 clk = ~clk;

	srs_bus_if #(.DATA_W(DW)) i_srs_bus_if (.hclk(clk), .reset(reset));
	srs_split_slave #(.DATA_W(DW)) i_srs_split_slave (.bus(i_srs_bus_if.slave), .pending(pending),
		.guard_hit(guard_hit));
	srs_bus_master #(.DATA_W(DW)) i_srs_bus_master (.bus(i_srs_bus_if.master), .cmd_valid(cmd_valid),
		.cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_write(cmd_write), .cmd_size(cmd_size),
		.cmd_lock(cmd_lock), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
		.done_err(done_err), .done_data(done_data), .done_tries(done_tries));
	srs_bus_assertions i_srs_bus_assertions (.hclk(clk), .reset(reset), .hsel(i_srs_bus_if.hsel),
		.htrans(i_srs_bus_if.htrans), .hsize(i_srs_bus_if.hsize), .hmaster(i_srs_bus_if.hmaster),
		.hmastlock(i_srs_bus_if.hmastlock), .hready(i_srs_bus_if.hready), .hresp(i_srs_bus_if.hresp),
		.hsplit(i_srs_bus_if.hsplit));

	// split responses and release pulses seen on the wire
	always @(posedge clk) begin
		if (!reset) begin
			if (!i_srs_bus_if.hready && i_srs_bus_if.hresp === srs_pkg::RSP_SPLIT) split_cnt++;
			rel_cnt += $countones(i_srs_bus_if.hsplit);
		end
	end

	task automatic report_and_stop();
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check_data(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t data got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t field got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_up();
		failures++;
		$display("ERROR %0t wait limit reached", $time);
		report_and_stop();
	endtask

	// one command, entered and finished at falling edges
	task automatic run_cmd(input logic [3:0] id, input logic [7:0] addr, input logic wr,
		input logic [2:0] sz, input logic lk);
		logic [31:0] wd, exp, mask;
		logic [7:0]  base;
		logic        seen;
		int          n;
		int          i;
		wd = $urandom;
		exp = '0;
		mask = '0;
		seen = 1'b0;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n >= 100) give_up();
		cmd_id = id;
		base = addr & ~8'((1 << sz) - 1);
		cmd_addr = 32'(base);
		cmd_write = wr;
		cmd_size = sz;
		cmd_lock = lk;
		cmd_wdata = DW'(wd);
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(negedge clk);
			seen |= pending[id];
			n++;
		end
		if (n >= 100) give_up();
		if (sz > 3'h2) begin
			check_flag(8'(done_err), 8'h01);
		end else begin
			for (i = 0; i < (1 << sz); i++) begin
				if (wr) mem[int'(base) + i] = wd[8*i +: 8];
				exp[8*i +: 8] = mem[int'(base) + i];
				mask[8*i +: 8] = 8'hFF;
			end
			check_flag(8'(done_err), 8'h00);
			check_flag(done_tries, lk ? 8'h01 : 8'h02);
			check_flag(8'(seen), lk ? 8'h00 : 8'h01);
			if (!wr) check_data(done_data & DW'(mask), DW'(exp));
			if (!lk) exp_splits++;
		end
		check_data(DW'(pending), '0);
	endtask

	initial begin
		void'($urandom(96));
		repeat (10) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		for (k = 0; k < 256; k += 4) run_cmd(4'(k >> 2), 8'(k), 1'b1, 3'h2, k % 16 == 0);
		for (k = 0; k < 120; k++) run_cmd(4'($urandom), 8'($urandom), 1'($urandom), 3'($urandom % 3),
			$urandom % 4 == 0);
		for (k = 3; k < 8; k++) run_cmd(4'(k), 8'h00, 1'b0, 3'(k), 1'b0);
		check_data(DW'(split_cnt), DW'(exp_splits));
		check_data(DW'(rel_cnt), DW'(exp_splits));
		check_flag(8'(guard_hit), 8'h00);
		report_and_stop();
	end
endmodule

`default_nettype wire
